// file: rtl/cmo_regs.sv
// Manufacturer option register bank reached over the management link
//
// Operation
// - History command answers a block read of exactly 32 bytes of status words.
// - History capture starts right after output ramp-up completes, never earlier.
// - One status word every 8 s over first 128 s, sixteen entries.
// - Entry n sits at bits 16n+15..16n; entry 0 lowest, sent first.
// - Special options is a read/write byte; bits 0, 1 and 4 reserved.
// - Options bit 7 set: writes need a valid PEC byte from host.
// - Options bit 6 enables ratio tracking mode.
// - Ratio tracking active while input is below undervoltage warning limit.
// - Options bit 5 selects droop: 0 linear, 1 non-linear.
// - Options bit 3 enables adaptive ramp and dynamic loop compensation.
// - Options bit 2 enables dynamic bus voltage.
// - Internal temperature offset is a read-only word in 0.1 degree units.
// - Remote temperature equals slope times sensor reading plus offset.
// - Remote calibration read returns four bytes: offset low two, slope high two.
`timescale 1ns/10ps
`include "cmo_map.svh"

module cmo_regs #(
    parameter logic [6:0] DEV_ADDR = `CMO_DEV_ADDR_DEFAULT,
    parameter logic [31:0] CAPTURE_CYCLES = 32'(`CMO_CAPTURE_INTERVAL_S * `CMO_CLK_HZ)
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic RAMP_DONE,
    input wire cmo_pkg::cmo_word_t STATUS_WORD,
    input wire cmo_pkg::cmo_word_t TEMP_OFFSET_INT,
    input wire cmo_pkg::cmo_word_t REMOTE_CAL_OFFSET,
    input wire cmo_pkg::cmo_word_t REMOTE_CAL_SLOPE,
    input wire cmo_pkg::cmo_word_t REMOTE_SENSOR_READING,
    input wire cmo_pkg::cmo_word_t VIN_LEVEL,
    input wire cmo_pkg::cmo_word_t INPUT_UNDERVOLTAGE_WARNING_LIMIT,
    output logic PEC_REQUIRED,
    output logic RATIO_TRACKING_ENABLE,
    output logic RATIO_TRACKING_ACTIVE,
    output logic DROOP_SLOPE_SELECT,
    output logic ADAPTIVE_RAMP_LOOP_COMP,
    output logic DYNAMIC_BUS_VOLTAGE_ENABLE,
    output cmo_pkg::cmo_byte_t REMOTE_CONTROL_CONFIG,
    output cmo_pkg::cmo_dword_t REMOTE_TEMP
);
    import cmo_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ `CMO_CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    // Data bytes of a read, count byte included for blocks; zero means unmapped
    function automatic logic [5:0] rd_len(input logic [7:0] cmd);
        case (cmd)
            `CMO_CMD_HISTORY: rd_len = `CMO_HIST_BYTES + `CMO_BYTE_BYTES;
            `CMO_CMD_REMOTE_CAL: rd_len = `CMO_CAL_BYTES + `CMO_BYTE_BYTES;
            `CMO_CMD_TEMP_OFFSET: rd_len = `CMO_WORD_BYTES;
            `CMO_CMD_OPTIONS: rd_len = `CMO_BYTE_BYTES;
            `CMO_CMD_REMOTE_CTRL: rd_len = `CMO_BYTE_BYTES;
            default: rd_len = 6'h00;
        endcase
    endfunction

    function automatic logic cmd_writable(input logic [7:0] cmd);
        return (cmd == `CMO_CMD_OPTIONS) || (cmd == `CMO_CMD_REMOTE_CTRL);
    endfunction

    cmo_regs_s q;
    cmo_regs_s d;
    logic [2:0] sync_lvl;
    logic scl_s;
    logic sda_s;
    logic ramp_s;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [255:0] hist_flat;
    logic [31:0] cal_flat;
    logic [5:0] tx_len;
    logic [5:0] tx_k;
    logic [7:0] tx_data;
    logic [7:0] tx_byte;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    cmo_sync u_sync (
        .clk(CLK),
        .rst_b(RST_B),
        .async_in({RAMP_DONE, SDA_IN, SCL}),
        .level_out(sync_lvl)
    );

    assign scl_s = sync_lvl[`CMO_SYNC_SCL];
    assign sda_s = sync_lvl[`CMO_SYNC_SDA];
    assign ramp_s = sync_lvl[`CMO_SYNC_RAMP];
    assign scl_rise = scl_s & ~q.scl_p;
    assign scl_fall = ~scl_s & q.scl_p;
    assign start_c = scl_s & q.scl_p & q.sda_p & ~sda_s;
    assign stop_c = scl_s & q.scl_p & ~q.sda_p & sda_s;

    // ----------------------------------------
    // Read data selection
    // ----------------------------------------
    assign hist_flat = q.hist;
    assign cal_flat = {REMOTE_CAL_SLOPE, REMOTE_CAL_OFFSET};
    assign tx_len = rd_len(q.cmd);
    assign tx_k = q.idx - 6'h01;

    always_comb begin
        case (q.cmd)
            `CMO_CMD_HISTORY: begin
                if (q.idx == 6'h00) begin
                    tx_data = {2'b00, `CMO_HIST_BYTES};
                end else begin
                    tx_data = hist_flat[{tx_k[4:0], 3'b000} +: 8];
                end
            end
            `CMO_CMD_REMOTE_CAL: begin
                if (q.idx == 6'h00) begin
                    tx_data = {2'b00, `CMO_CAL_BYTES};
                end else begin
                    tx_data = cal_flat[{tx_k[1:0], 3'b000} +: 8];
                end
            end
            `CMO_CMD_TEMP_OFFSET: begin
                tx_data = q.idx[0] ? TEMP_OFFSET_INT[15:8] : TEMP_OFFSET_INT[7:0];
            end
            `CMO_CMD_OPTIONS: tx_data = q.opt & `CMO_OPT_WMASK;
            `CMO_CMD_REMOTE_CTRL: tx_data = q.rc;
            default: tx_data = 8'hFF;
        endcase
        // PEC follows the data; anything past it reads as idle bus
        if (q.idx < tx_len) begin
            tx_byte = tx_data;
        end else if (q.idx == tx_len) begin
            tx_byte = q.crc;
        end else begin
            tx_byte = 8'hFF;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        d = q;
        d.scl_p = scl_s;
        d.sda_p = sda_s;
        d.sda_o = 1'b0;

        if (start_c) begin
            d.st = CMO_ADDR;
            d.bitcnt = 4'h0;
            d.sda_oe = 1'b0;
        end else if (stop_c) begin
            // Write takes effect only at stop, after the PEC verdict
            if (cmd_writable(q.cmd) && q.wcnt != 2'h0) begin
                if ((q.wcnt == 2'h2) ? q.pec_ok : !q.opt[`CMO_OPT_PEC]) begin
                    if (q.cmd == `CMO_CMD_OPTIONS) begin
                        d.opt = q.wbuf & `CMO_OPT_WMASK;
                    end else begin
                        d.rc = q.wbuf;
                    end
                end
            end
            d.st = CMO_IDLE;
            d.wcnt = 2'h0;
            d.crc = 8'h00;
            d.sda_oe = 1'b0;
        end else begin
            case (q.st)
                CMO_ADDR, CMO_CMD, CMO_WDATA: begin
                    if (scl_rise && q.bitcnt != 4'h8) begin
                        d.shreg = {q.shreg[6:0], sda_s};
                        d.bitcnt = q.bitcnt + 4'h1;
                    end else if (scl_fall && q.bitcnt == 4'h8) begin
                        d.st = CMO_IDLE;
                        d.bitcnt = 4'h0;
                        if (q.st == CMO_ADDR) begin
                            if (q.shreg[7:1] == DEV_ADDR) begin
                                d.st = CMO_ACK;
                                d.sda_oe = 1'b1;
                                d.rw = q.shreg[0];
                                d.nxt = q.shreg[0] ? CMO_TX : CMO_CMD;
                                d.idx = 6'h00;
                                d.crc = crc8(q.crc, q.shreg);
                            end
                        end else if (q.st == CMO_CMD) begin
                            if (rd_len(q.shreg) != 6'h00) begin
                                d.st = CMO_ACK;
                                d.sda_oe = 1'b1;
                                d.cmd = q.shreg;
                                d.nxt = CMO_WDATA;
                                d.wcnt = 2'h0;
                                d.pec_ok = 1'b0;
                                d.crc = crc8(q.crc, q.shreg);
                            end
                        end else if (cmd_writable(q.cmd) && q.wcnt != 2'h2) begin
                            d.st = CMO_ACK;
                            d.sda_oe = 1'b1;
                            d.nxt = CMO_WDATA;
                            d.wcnt = q.wcnt + 2'h1;
                            if (q.wcnt == 2'h0) begin
                                d.wbuf = q.shreg;
                                d.crc = crc8(q.crc, q.shreg);
                            end else begin
                                d.pec_ok = (q.shreg == q.crc);
                            end
                        end
                    end
                end
                CMO_ACK, CMO_MACK: begin
                    if (scl_rise && q.st == CMO_MACK) begin
                        d.mack_ok = ~sda_s;
                    end else if (scl_fall) begin
                        d.sda_oe = 1'b0;
                        d.st = q.nxt;
                        if (q.st == CMO_MACK && !q.mack_ok) begin
                            d.st = CMO_IDLE;
                        end else if (q.nxt == CMO_TX) begin
                            // Load a byte and drive its first bit on this edge
                            d.shreg = tx_byte;
                            d.sda_oe = ~tx_byte[7];
                            d.bitcnt = 4'h1;
                            if (q.idx < tx_len) begin
                                d.crc = crc8(q.crc, tx_byte);
                            end
                            if (q.idx != 6'h3F) begin
                                d.idx = q.idx + 6'h01;
                            end
                        end
                    end
                end
                CMO_TX: begin
                    if (scl_fall) begin
                        if (q.bitcnt == 4'h8) begin
                            d.sda_oe = 1'b0;
                            d.st = CMO_MACK;
                            d.nxt = CMO_TX;
                            d.mack_ok = 1'b0;
                        end else begin
                            d.sda_oe = ~q.shreg[6];
                            d.shreg = {q.shreg[6:0], 1'b1};
                            d.bitcnt = q.bitcnt + 4'h1;
                        end
                    end
                end
                default: begin
                    d.st = CMO_IDLE;
                    d.sda_oe = 1'b0;
                end
            endcase
        end

        // ----------------------------------------
        // Start-up status history
        // ----------------------------------------
        if (!q.hist_on) begin
            if (ramp_s) begin
                d.hist_on = 1'b1;
                d.hist[0] = STATUS_WORD;
                d.hist_cnt = 5'h01;
                d.timer = 32'h0000_0000;
            end
        end else if (q.hist_cnt != `CMO_HIST_ENTRIES) begin
            if (q.timer >= CAPTURE_CYCLES - 32'h0000_0001) begin
                d.hist[q.hist_cnt[3:0]] = STATUS_WORD;
                d.hist_cnt = q.hist_cnt + 5'h01;
                d.timer = 32'h0000_0000;
            end else begin
                d.timer = q.timer + 32'h0000_0001;
            end
        end

        // ----------------------------------------
        // Regulation hooks
        // ----------------------------------------
        d.rt_active = q.opt[`CMO_OPT_RATIO] && (VIN_LEVEL < INPUT_UNDERVOLTAGE_WARNING_LIMIT);
        d.rtemp = (32'(REMOTE_CAL_SLOPE) * 32'(REMOTE_SENSOR_READING))
            + {16'h0000, REMOTE_CAL_OFFSET};
    end

    // Uncaptured entries stay zero, as cleared here
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            q <= '0;
            q.st <= CMO_IDLE;
            q.nxt <= CMO_IDLE;
            q.scl_p <= 1'b1;
            q.sda_p <= 1'b1;
            q.opt <= `CMO_OPT_RESET;
            q.rc <= `CMO_RC_RESET;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign SDA_OUT = q.sda_o;
    assign SDA_OE = q.sda_oe;
    assign PEC_REQUIRED = q.opt[`CMO_OPT_PEC];
    assign RATIO_TRACKING_ENABLE = q.opt[`CMO_OPT_RATIO];
    assign RATIO_TRACKING_ACTIVE = q.rt_active;
    assign DROOP_SLOPE_SELECT = q.opt[`CMO_OPT_DROOP];
    assign ADAPTIVE_RAMP_LOOP_COMP = q.opt[`CMO_OPT_ARLC];
    assign DYNAMIC_BUS_VOLTAGE_ENABLE = q.opt[`CMO_OPT_DBV];
    assign REMOTE_CONTROL_CONFIG = q.rc;
    assign REMOTE_TEMP = q.rtemp;
endmodule

// file: common/cmo_map.svh
// Offsets, field positions, reset values and timing counts of the option registers
`ifndef CMO_MAP_SVH
`define CMO_MAP_SVH

`define CMO_CMD_HISTORY 8'hDF
`define CMO_CMD_OPTIONS 8'hE0
`define CMO_CMD_TEMP_OFFSET 8'hE1
`define CMO_CMD_REMOTE_CAL 8'hE2
`define CMO_CMD_REMOTE_CTRL 8'hE3

`define CMO_OPT_PEC 7
`define CMO_OPT_RATIO 6
`define CMO_OPT_DROOP 5
`define CMO_OPT_ARLC 3
`define CMO_OPT_DBV 2
`define CMO_OPT_WMASK 8'hEC
`define CMO_OPT_RESET 8'h00
`define CMO_RC_RESET 8'h00

`define CMO_HIST_BYTES 6'h20
`define CMO_HIST_ENTRIES 5'h10
`define CMO_CAL_BYTES 6'h04
`define CMO_WORD_BYTES 6'h02
`define CMO_BYTE_BYTES 6'h01

`define CMO_CAPTURE_INTERVAL_S 8
`define CMO_CLK_HZ 100000000

`define CMO_CRC_POLY 8'h07
`define CMO_DEV_ADDR_DEFAULT 7'h40
`define CMO_SYNC_RESET 3'b011
`define CMO_SYNC_SCL 0
`define CMO_SYNC_SDA 1
`define CMO_SYNC_RAMP 2

`endif

// file: common/cmo_pkg.sv
// Types shared by the option register bank and its input synchroniser
package cmo_pkg;

    typedef logic [15:0] cmo_word_t;
    typedef logic [7:0] cmo_byte_t;
    typedef logic [31:0] cmo_dword_t;

    typedef enum logic [2:0] {
        CMO_IDLE,
        CMO_ADDR,
        CMO_CMD,
        CMO_WDATA,
        CMO_ACK,
        CMO_TX,
        CMO_MACK
    } cmo_state_e;

    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] lvl;
    } cmo_sync_s;

    typedef struct packed {
        cmo_state_e st;
        cmo_state_e nxt;
        logic scl_p;
        logic sda_p;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic rw;
        logic mack_ok;
        logic [7:0] cmd;
        logic [5:0] idx;
        logic [7:0] wbuf;
        logic [1:0] wcnt;
        logic pec_ok;
        logic [7:0] crc;
        logic sda_oe;
        logic sda_o;
        logic [7:0] opt;
        logic [7:0] rc;
        logic [15:0][15:0] hist;
        logic [4:0] hist_cnt;
        logic hist_on;
        logic [31:0] timer;
        logic rt_active;
        logic [31:0] rtemp;
    } cmo_regs_s;

endpackage

// file: rtl/cmo_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
`include "cmo_map.svh"

module cmo_sync (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [2:0] async_in,
    output logic [2:0] level_out
);
    import cmo_pkg::*;

    cmo_sync_s q;
    cmo_sync_s d;

    // First stage is read only by the second stage
    always_comb begin
        d = q;
        d.s1 = async_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.lvl = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.lvl);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q <= {4{`CMO_SYNC_RESET}};
        end else begin
            q <= d;
        end
    end

    assign level_out = q.lvl;
endmodule

// file: tb/cmo_checker.sv
// Port assertions for the option register bank
`timescale 1ns/10ps
module cmo_checker (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic SCL,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE,
    input wire cmo_pkg::cmo_word_t REMOTE_CAL_OFFSET,
    input wire cmo_pkg::cmo_word_t REMOTE_CAL_SLOPE,
    input wire cmo_pkg::cmo_word_t REMOTE_SENSOR_READING,
    input wire cmo_pkg::cmo_word_t VIN_LEVEL,
    input wire cmo_pkg::cmo_word_t INPUT_UNDERVOLTAGE_WARNING_LIMIT,
    input wire logic PEC_REQUIRED,
    input wire logic RATIO_TRACKING_ENABLE,
    input wire logic RATIO_TRACKING_ACTIVE,
    input wire logic DROOP_SLOPE_SELECT,
    input wire logic ADAPTIVE_RAMP_LOOP_COMP,
    input wire logic DYNAMIC_BUS_VOLTAGE_ENABLE,
    input wire cmo_pkg::cmo_byte_t REMOTE_CONTROL_CONFIG,
    input wire cmo_pkg::cmo_dword_t REMOTE_TEMP
);
    import cmo_pkg::*;
    logic [4:0] opts;
    logic [7:0] oe_cnt_q;
    assign opts = {PEC_REQUIRED, RATIO_TRACKING_ENABLE, DROOP_SLOPE_SELECT,
        ADAPTIVE_RAMP_LOOP_COMP, DYNAMIC_BUS_VOLTAGE_ENABLE};
    // Saturates, so a stuck drive cannot wrap back under the limit
    always_ff @(posedge CLK) begin
        if (!RST_B || !SDA_OE) begin
            oe_cnt_q <= 8'h00;
        end else if (oe_cnt_q != 8'hFF) begin
            oe_cnt_q <= oe_cnt_q + 8'h01;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // ----------
    // Assertions
    // ----------
    property p_sda_low;
        SDA_OUT == 1'b0;
    endproperty
    a_sda_low: assert property (p_sda_low) else $error("sda drive value high");
    property p_oe_edge;
        $changed(SDA_OE) |-> !SCL && !$past(SCL, 3);
    endproperty
    a_oe_edge: assert property (p_oe_edge) else $error("sda drive moved near scl high");
    // Nine bit cells at most: eight zero bits plus the address acknowledge
    property p_oe_len;
        oe_cnt_q < 8'h50;
    endproperty
    a_oe_len: assert property (p_oe_len) else $error("sda held low too long");
    property p_opts_stop;
        $changed(opts) |-> SCL && SDA_IN && $past(SCL, 4);
    endproperty
    a_opts_stop: assert property (p_opts_stop) else $error("options moved outside stop");
    property p_rc_stop;
        $changed(REMOTE_CONTROL_CONFIG) |-> SCL && SDA_IN && $past(SCL, 4);
    endproperty
    a_rc_stop: assert property (p_rc_stop) else $error("config moved outside stop");
    property p_rst_zero;
        $rose(RST_B) |-> opts == 5'h00 && REMOTE_CONTROL_CONFIG == 8'h00;
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("outputs not clear after reset");
    property p_ratio;
        RATIO_TRACKING_ENABLE == $past(RATIO_TRACKING_ENABLE) |-> RATIO_TRACKING_ACTIVE ==
            $past(RATIO_TRACKING_ENABLE && VIN_LEVEL < INPUT_UNDERVOLTAGE_WARNING_LIMIT);
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio tracking state wrong");
    property p_rtemp;
        $past(RST_B) |-> REMOTE_TEMP == $past(32'(REMOTE_CAL_SLOPE) *
            32'(REMOTE_SENSOR_READING) + 32'(REMOTE_CAL_OFFSET));
    endproperty
    a_rtemp: assert property (p_rtemp) else $error("remote temperature wrong");
endmodule

// file: tb/cmo_host.sv
// Management link host model driving SCL and its side of open-drain SDA
`timescale 1ns/10ps
module cmo_host #(
    parameter logic [6:0] ADDR = 7'h40
) (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_drv
);
    logic [7:0] rb [0:33];
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        repeat (8) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
        return r;
    endfunction
    // Waits first so SDA never moves in the cycle SCL falls
    task automatic start();
        tick(6);
        sda_drv <= 1'b1;
        tick(6);
        scl <= 1'b1;
        tick(6);
        sda_drv <= 1'b0;
        tick(6);
        scl <= 1'b0;
    endtask
    // 80 ns cell; SCL rises one clock after the device's drive has landed
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            tick(2);
            sda_drv <= tx[i];
            tick(4);
            scl <= 1'b1;
            tick(2);
            rx[i] = sda;
            scl <= 1'b0;
        end
    endtask
    task automatic stop();
        tick(6);
        sda_drv <= 1'b0;
        tick(6);
        scl <= 1'b1;
        tick(6);
        sda_drv <= 1'b1;
        tick(12);
    endtask
    // Pec mode: 0 none, 1 good, 2 corrupted
    task automatic wr(input logic [7:0] cmd, input logic [7:0] d, input int pm, output logic nak);
        logic [8:0] rx;
        logic [7:0] c;
        c = crc8(crc8(crc8(8'h00, {ADDR, 1'b0}), cmd), d);
        start();
        xfer({ADDR, 1'b0, 1'b1}, rx);
        xfer({cmd, 1'b1}, rx);
        xfer({d, 1'b1}, rx);
        nak = rx[0];
        if (pm != 0) begin
            xfer({c ^ 8'(pm - 1), 1'b1}, rx);
        end
        stop();
    endtask
    task automatic rd(input logic [7:0] cmd, input int n);
        logic [8:0] rx;
        start();
        xfer({ADDR, 1'b0, 1'b1}, rx);
        xfer({cmd, 1'b1}, rx);
        start();
        xfer({ADDR, 1'b1, 1'b1}, rx);
        for (int i = 0; i < n; i++) begin
            xfer({8'hFF, i == n - 1}, rx);
            rb[i] = rx[8:1];
        end
        stop();
    endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the option register bank
`timescale 1ns/10ps
`include "cmo_map.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
    import cmo_pkg::*;
    localparam logic [31:0] CAP = 32'h0000_0032;
    logic clk, rst_b, ramp, scl, sda_drv, sda, oe, sda_o;
    logic pec, rte, rta, droop_slope_select, arl, dynamic_bus_voltage_enable;
    cmo_word_t status, toff, c_off, c_slp, rdg, vin, lim;
    cmo_byte_t rcc;
    cmo_dword_t rtemp;
    int error_cnt = 0;
    int n_checks = 0;
    // Pulled up unless either side pulls low
    assign sda = sda_drv & ~oe;
    cmo_host host (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
    cmo_regs #(.CAPTURE_CYCLES(CAP)) uut (.CLK(clk), .RST_B(rst_b), .SCL(scl), .SDA_IN(sda),
        .SDA_OUT(sda_o), .SDA_OE(oe), .RAMP_DONE(ramp), .STATUS_WORD(status),
        .TEMP_OFFSET_INT(toff), .REMOTE_CAL_OFFSET(c_off), .REMOTE_CAL_SLOPE(c_slp),
        .REMOTE_SENSOR_READING(rdg), .VIN_LEVEL(vin), .INPUT_UNDERVOLTAGE_WARNING_LIMIT(lim),
        .PEC_REQUIRED(pec), .RATIO_TRACKING_ENABLE(rte), .RATIO_TRACKING_ACTIVE(rta),
        .DROOP_SLOPE_SELECT(droop_slope_select), .ADAPTIVE_RAMP_LOOP_COMP(arl),
        .DYNAMIC_BUS_VOLTAGE_ENABLE(dynamic_bus_voltage_enable), .REMOTE_CONTROL_CONFIG(rcc), .REMOTE_TEMP(rtemp));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic close_out();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #1_000_000;
        error_cnt++;
        close_out();
    end
    // ---------
    // Scenarios
    // ---------
    task automatic t_reset();
        `CHK({pec, rte, rta, droop_slope_select, arl, dynamic_bus_voltage_enable, rcc}, 14'h0000)
        host.rd(8'hDF, 33);
        `CHK(host.rb[0], 8'h20)
        for (int i = 1; i < 33; i++) `CHK(host.rb[i], 8'h00)
    endtask
    task automatic t_opts();
        logic n;
        logic [7:0] v [3] = '{8'h7F, 8'h24, 8'h48};
        foreach (v[i]) begin
            host.wr(8'hE0, v[i], 0, n);
            `CHK({n, pec, rte, droop_slope_select, arl, dynamic_bus_voltage_enable}, {1'b0, v[i][7:5], v[i][3:2]})
            host.rd(8'hE0, 1);
            `CHK(host.rb[0], v[i] & `CMO_OPT_WMASK)
        end
        host.wr(8'hE3, 8'h5A, 0, n);
        host.rd(8'hE3, 1);
        `CHK({n, rcc, host.rb[0]}, {1'b0, 8'h5A, 8'h5A})
    endtask
    task automatic t_pec();
        logic n;
        host.wr(8'hE0, 8'h80, 1, n);
        `CHK(pec, 1'b1)
        host.wr(8'hE0, 8'h04, 0, n);
        `CHK(dynamic_bus_voltage_enable, 1'b0)
        host.wr(8'hE0, 8'h04, 2, n);
        `CHK(dynamic_bus_voltage_enable, 1'b0)
        host.wr(8'hE0, 8'h04, 1, n);
        `CHK({pec, dynamic_bus_voltage_enable}, 2'b01)
    endtask
    task automatic t_ratio();
        logic n;
        host.wr(8'hE0, 8'h40, 0, n);
        vin <= 16'h0FFF;
        repeat (3) @(posedge clk);
        `CHK(rta, 1'b1)
        vin <= 16'h1000;
        repeat (3) @(posedge clk);
        `CHK(rta, 1'b0)
        vin <= 16'h0000;
        host.wr(8'hE0, 8'h00, 0, n);
        `CHK({rte, rta}, 2'b00)
    endtask
    task automatic t_words();
        logic n;
        logic [39:0] cal;
        host.rd(8'hE1, 2);
        `CHK({host.rb[1], host.rb[0]}, toff)
        host.wr(8'hE1, 8'h55, 0, n);
        `CHK(n, 1'b1)
        host.rd(8'hE2, 5);
        cal = {host.rb[4], host.rb[3], host.rb[2], host.rb[1], host.rb[0]};
        `CHK(cal, {c_slp, c_off, 8'h04})
        `CHK(rtemp, 32'(c_slp) * 32'(rdg) + 32'(c_off))
        c_off <= 16'hFFFF;
        c_slp <= 16'hFFFF;
        rdg <= 16'hFFFF;
        repeat (3) @(posedge clk);
        `CHK(rtemp, 32'hFFFF_0000)
    endtask
    // Status steps a few cycles before each capture, so captures landing a few cycles late are harmless
    task automatic t_hist();
        ramp <= 1'b1;
        for (int k = 0; k < 16 * CAP + 30; k++) begin
            status <= 16'hA500 + 16'(k / CAP);
            @(posedge clk);
        end
        status <= 16'hFFFF;
        host.rd(8'hDF, 33);
        `CHK(host.rb[0], 8'h20)
        for (int i = 0; i < 16; i++) `CHK({host.rb[2*i+2], host.rb[2*i+1]}, 16'hA500 + 16'(i))
    endtask
    initial begin
        rst_b = 1'b0;
        ramp = 1'b0;
        status = 16'h1234;
        toff = 16'hBEEF;
        c_off = 16'h1234;
        c_slp = 16'hABCD;
        rdg = 16'h0003;
        vin = 16'hFFFF;
        lim = 16'h1000;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
        t_reset();
        t_opts();
        t_pec();
        t_ratio();
        t_words();
        t_hist();
        close_out();
    end
endmodule
bind cmo_regs cmo_checker chk (.*);
